// ==== fault_led_cfg.svh ====
// Constants for the fault, status and ID indicator controller
// Overview of operation
// [R1] Every error source has its own enable
// [R2] PCI system error reaches NMI only when enabled
// [R3] Unrecoverable processor-bus error drives bus error, NMI
// [R4] ECC single or double error raises SMI
// [R5] One latched LED per memory module error
// [R6] One processor LED lit while processor disabled
// [R7] Per-fan LEDs plus combined assembly fan LED
// [R8] Fault LED image saved and restored after AC
// [R9] Clear only by powered panel reset or command
// [R10] Status LED colour and blink encode state
// [R11] Board and front status LEDs share source
// [R12] Critical state entered from listed critical events
// [R13] Power stays on after power-off means failure
// [R14] Non-critical state from thresholds, intrusion, satellite
// [R15] Degraded from disabled processor, mapped memory, redundancy
// [R16] ID LED toggles on each ID press
// [R17] Most severe active state is shown
// [R18] Blinking uses one configurable even blink period
`ifndef FAULT_LED_CFG_SVH
`define FAULT_LED_CFG_SVH
// Register byte offsets
`define REG_CTRL 12'h000
`define REG_COND 12'h004
`define REG_FAULT 12'h008
`define REG_STATUS 12'h00C
`define REG_BLINK 12'h010
// Control register fields
`define CTRL_PCI_NMI_EN 0
`define CTRL_PROC_NMI_EN 1
`define CTRL_MEM_SMI_EN 2
`define CTRL_SENS_SMI_EN 3
`define CTRL_REDUNDANT 4
`define CTRL_FAULT_CLR 8
`define CTRL_RST 32'h0000001F
// Condition register fields (software-reported events)
`define COND_SAT_CRIT 0
`define COND_SAT_NONCRIT 1
`define COND_LOG_ERR 2
`define COND_MEM_MAPOUT 3
`define COND_POST_STOP 4
`define COND_RST 32'h00000010
// Indicator counts
`define NUM_DIMM 6
`define NUM_CPU 2
`define NUM_FAN 4
`define FAULT_W 13
// Fans fed from the assembly header
`define FAN_ASSY_MASK 4'h3
// Blink half period in clock cycles, reset value
`define BLINK_RST 32'h005F5E10
// Power-off failure timeout
`define CLK_HZ 25000000
`define PWR_FAIL_US 1000
`define PWR_FAIL_CYC ((`PWR_FAIL_US * (`CLK_HZ / 1000000)))
`endif

// ==== fault_led_pkg.sv ====
// Types shared by the indicator controller
package fault_led_pkg;
  // One-hot status LED states
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_NORMAL = 5'b00010,
    ST_DEGRADED = 5'b00100,
    ST_NONCRIT = 5'b01000,
    ST_CRIT = 5'b10000
  } sys_state_e;
  // Two-colour LED drive
  typedef struct packed {
    logic green;
    logic amber;
  } led_s;
  // Latched fault indicators
  typedef struct packed {
    logic fan_assy;
    logic [3:0] fan;
    logic [1:0] cpu;
    logic [5:0] dimm;
  } fault_s;
endpackage

// ==== fault_led_ctrl.sv ====
// Error routing, latched fault LEDs, status and ID LED controller
`timescale 1ns/100ps
`default_nettype none
`include "fault_led_cfg.svh"
module fault_led_ctrl import fault_led_pkg::*; #(
  parameter int PWR_FAIL_CYCLES = `PWR_FAIL_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Error sources
  input wire logic pci_serr,
  input wire logic proc_bus_unrec_err,
  input wire logic ecc_present,
  input wire logic mem_sbe,
  input wire logic mem_dbe,
  input wire logic sensor_event,
  output logic proc_bus_error_out,
  output logic nmi,
  output logic smi,
  // Fault sources
  input wire logic [5:0] dimm_uncorr,
  input wire logic [1:0] cpu_disabled,
  input wire logic [3:0] fan_fail,
  // Condition sources
  input wire logic thr_crit,
  input wire logic thr_noncrit,
  input wire logic chassis_intrusion,
  input wire logic cpu_install_fail,
  input wire logic nonredundant_pwr,
  input wire logic pwr_off_req,
  input wire logic sys_pwr_on,
  // Front panel and power
  input wire logic main_power,
  input wire logic fp_reset,
  input wire logic id_button,
  // Nonvolatile fault image
  input wire logic [12:0] nv_image_in,
  output logic [12:0] nv_image_out,
  // Indicator outputs
  output fault_s fault_led,
  output led_s board_status_led,
  output led_s panel_status_led,
  output logic id_led
);
  // Register state
  logic [31:0] ctrl_q; // Enables and configuration
  logic [31:0] cond_q; // Software-reported conditions
  logic [31:0] blink_q; // Blink half period
  logic [31:0] prdata_q; // Read data
  logic clr_cmd_q; // Fault clear command pulse
  fault_s fault_q; // Latched faults
  logic restore_q; // Image load pending
  logic nmi_q, smi_q, proc_bus_error_out_q; // Interrupt outputs
  logic pwr_fail_q; // Power subsystem failure
  logic [31:0] pwr_cnt_q; // Power-off timeout count
  logic [31:0] blink_cnt_q; // Blink counter
  logic blink_ph_q; // Blink phase
  logic id_q, id_prev_q; // ID LED and button sample
  sys_state_e state_q, state_d; // Status LED state
  led_s led_q; // Status LED drive
  logic wr_en, rd_en, addr_ok; // Bus decode
  logic fault_clr; // Any clearing event
  logic crit, noncrit, degraded; // Condition groups

  // Bus decode, zero wait states
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_COND) || (paddr == `REG_FAULT) ||
                   (paddr == `REG_STATUS) || (paddr == `REG_BLINK);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_q;

  // Control and condition registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `CTRL_RST;
      cond_q <= `COND_RST;
      blink_q <= `BLINK_RST;
    end else if (wr_en) begin
      // Writable registers
      case (paddr)
        `REG_CTRL: ctrl_q <= {27'h0, pwdata[4:0]};
        `REG_COND: cond_q <= {27'h0, pwdata[4:0]};
        `REG_BLINK: blink_q <= (pwdata == 32'h0) ? 32'h00000001 : pwdata;
        default: ;
      endcase
    end
  end

  // Clear command pulse from a control write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_cmd_q <= 1'b0;
    end else begin
      clr_cmd_q <= wr_en && (paddr == `REG_CTRL) && pwdata[`CTRL_FAULT_CLR];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (rd_en) begin
      case (paddr)
        `REG_CTRL: prdata_q <= ctrl_q;
        `REG_COND: prdata_q <= cond_q;
        `REG_FAULT: prdata_q <= {19'h0, fault_q};
        `REG_STATUS: prdata_q <= {22'h0, pwr_fail_q, id_q, led_q, 1'b0, state_q};
        `REG_BLINK: prdata_q <= blink_q;
        default: prdata_q <= 32'h0;
      endcase
    end
  end

  // Error routing to NMI and SMI
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      proc_bus_error_out_q <= 1'b0;
      nmi_q <= 1'b0;
      smi_q <= 1'b0;
    end else begin
      // [R3] bus error raise
      proc_bus_error_out_q <= proc_bus_unrec_err;
      // [R1] [R2] [R3] gated NMI
      nmi_q <= (pci_serr && ctrl_q[`CTRL_PCI_NMI_EN]) ||
               (proc_bus_unrec_err && ctrl_q[`CTRL_PROC_NMI_EN]);
      // [R1] [R4] gated SMI
      smi_q <= (ecc_present && (mem_sbe || mem_dbe) && ctrl_q[`CTRL_MEM_SMI_EN]) ||
               (sensor_event && ctrl_q[`CTRL_SENS_SMI_EN]);
    end
  end
  assign proc_bus_error_out = proc_bus_error_out_q;
  assign nmi = nmi_q;
  assign smi = smi_q;

  // [R9] only powered panel reset or command
  assign fault_clr = (fp_reset && main_power) || clr_cmd_q;

  // Fault latches; new faults win over a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= '0;
      restore_q <= 1'b1;
    end else if (restore_q) begin
      // [R8] restore saved image
      fault_q <= fault_s'(nv_image_in);
      restore_q <= 1'b0;
    end else begin
      // [R5] [R6] [R7] set over clear
      fault_q.dimm <= dimm_uncorr | (fault_clr ? 6'h0 : fault_q.dimm);
      fault_q.cpu <= cpu_disabled | (fault_clr ? 2'h0 : fault_q.cpu);
      fault_q.fan <= fan_fail | (fault_clr ? 4'h0 : fault_q.fan);
      fault_q.fan_assy <= (|(fan_fail & `FAN_ASSY_MASK)) || (!fault_clr && fault_q.fan_assy);
    end
  end
  // [R8] image for nonvolatile save
  assign nv_image_out = fault_q;
  assign fault_led = fault_q;

  // [R13] power still on after power-off request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_cnt_q <= 32'h0;
      pwr_fail_q <= 1'b0;
    end else if (pwr_off_req && sys_pwr_on) begin
      if (pwr_cnt_q >= 32'(PWR_FAIL_CYCLES - 1)) begin
        pwr_fail_q <= 1'b1;
      end else begin
        pwr_cnt_q <= pwr_cnt_q + 32'h1;
      end
    end else begin
      pwr_cnt_q <= 32'h0;
      pwr_fail_q <= 1'b0;
    end
  end

  // Condition groups
  // [R12] critical events
  assign crit = thr_crit || pwr_fail_q || cpu_install_fail ||
                cond_q[`COND_SAT_CRIT] || cond_q[`COND_LOG_ERR];
  // [R14] non-critical events
  assign noncrit = thr_noncrit || chassis_intrusion || cond_q[`COND_SAT_NONCRIT];
  // [R15] degraded events
  assign degraded = (|cpu_disabled) || cond_q[`COND_MEM_MAPOUT] ||
                    (nonredundant_pwr && ctrl_q[`CTRL_REDUNDANT]);

  // [R17] severity ranking
  always_comb begin
    state_d = ST_NORMAL;
    if (cond_q[`COND_POST_STOP]) begin
      state_d = ST_OFF;
    end else if (crit) begin
      state_d = ST_CRIT;
    end else if (noncrit) begin
      state_d = ST_NONCRIT;
    end else if (degraded) begin
      state_d = ST_DEGRADED;
    end
  end

  // Status state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // [R18] configurable half-period blink
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_q <= 32'h0;
      blink_ph_q <= 1'b0;
    end else if (blink_cnt_q >= blink_q - 32'h1) begin
      blink_cnt_q <= 32'h0;
      blink_ph_q <= !blink_ph_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  // [R10] colour encoding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_q <= '0;
    end else begin
      case (state_q)
        ST_OFF: led_q <= '{green: 1'b0, amber: 1'b0};
        ST_NORMAL: led_q <= '{green: 1'b1, amber: 1'b0};
        ST_DEGRADED: led_q <= '{green: blink_ph_q, amber: 1'b0};
        ST_NONCRIT: led_q <= '{green: 1'b0, amber: blink_ph_q};
        ST_CRIT: led_q <= '{green: 1'b0, amber: 1'b1};
        default: led_q <= '0;
      endcase
    end
  end
  // [R11] single source for both LEDs
  assign board_status_led = led_q;
  assign panel_status_led = led_q;

  // [R16] ID toggle on press
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_prev_q <= 1'b0;
      id_q <= 1'b0;
    end else begin
      id_prev_q <= id_button;
      if (id_button && !id_prev_q) begin
        id_q <= !id_q;
      end
    end
  end
  assign id_led = id_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_PCI_NMI_GATE: assert property ( // [R2]
    pci_serr && !ctrl_q[`CTRL_PCI_NMI_EN] && !proc_bus_unrec_err |=> !nmi)
    else $error("NMI raised from masked PCI error");
  AST_PROC_PROC_BUS_ERROR_OUT: assert property ( // [R3]
    proc_bus_unrec_err |=> proc_bus_error_out)
    else $error("Bus error output missing");
  AST_MEM_SMI: assert property ( // [R4]
    ecc_present && mem_dbe && ctrl_q[`CTRL_MEM_SMI_EN] |=> smi)
    else $error("SMI missing on ECC error");
  AST_SMI_MASK: assert property ( // [R1]
    !ctrl_q[`CTRL_MEM_SMI_EN] && !ctrl_q[`CTRL_SENS_SMI_EN] |=> !smi)
    else $error("SMI with all sources masked");
  AST_DIMM_LATCH: assert property ( // [R5]
    !restore_q && dimm_uncorr[0] |=> fault_led.dimm[0])
    else $error("Memory fault LED not lit");
  AST_CPU_LED: assert property ( // [R6]
    !restore_q && cpu_disabled[1] |=> fault_led.cpu[1])
    else $error("Processor fault LED not lit");
  AST_FAN_ASSY: assert property ( // [R7]
    !restore_q && fan_fail[0] |=> fault_led.fan_assy && fault_led.fan[0])
    else $error("Fan fault LEDs not lit");
  AST_HOLD: assert property ( // [R9]
    !restore_q && !fault_clr && fault_led.cpu[0] |=> fault_led.cpu[0])
    else $error("Fault LED lost without clear");
  AST_CRIT_AMBER: assert property ( // [R10]
    state_q == ST_CRIT |=> board_status_led.amber && !board_status_led.green)
    else $error("Critical not steady amber");
  AST_SAME_LED: assert property ( // [R11]
    board_status_led == panel_status_led)
    else $error("Status LEDs differ");
  AST_SEVERITY: assert property ( // [R17]
    !cond_q[`COND_POST_STOP] && thr_crit && thr_noncrit |=> state_q == ST_CRIT)
    else $error("Critical not given priority");
  AST_ID_TOGGLE: assert property ( // [R16]
    id_button && !id_prev_q |=> id_led != $past(id_led))
    else $error("ID LED did not toggle");
  AST_PWR_FAIL: assert property ( // [R13]
    pwr_fail_q |-> $past(pwr_off_req) && $past(sys_pwr_on))
    else $error("Power failure without cause");
  AST_NMI_MASK: assert property ( // [R1]
    !ctrl_q[`CTRL_PCI_NMI_EN] && !ctrl_q[`CTRL_PROC_NMI_EN] |=> !nmi)
    else $error("NMI with all sources masked");
  AST_RESTORE: assert property ( // [R8]
    restore_q && rst_n |=> nv_image_out == $past(nv_image_in))
    else $error("Saved fault image not restored");
  AST_PANEL_CLEAR: assert property ( // [R9]
    !restore_q && fp_reset && main_power && !(|dimm_uncorr) |=> fault_led.dimm == 6'h00)
    else $error("Panel reset did not clear memory LEDs");
  AST_CMD_CLEAR: assert property ( // [R9]
    !restore_q && clr_cmd_q && !(|fan_fail) |=> fault_led.fan == 4'h0)
    else $error("Clear command did not clear fan LEDs");
  AST_NORMAL_GREEN: assert property ( // [R10]
    state_q == ST_NORMAL |=> board_status_led.green && !board_status_led.amber)
    else $error("Normal not steady green");
  AST_CRIT_ENTRY: assert property ( // [R12]
    !cond_q[`COND_POST_STOP] && (thr_crit || cpu_install_fail || pwr_fail_q)
    |=> state_q == ST_CRIT)
    else $error("Critical event did not enter critical");
  AST_NONCRIT: assert property ( // [R14]
    !cond_q[`COND_POST_STOP] && !crit && (thr_noncrit || chassis_intrusion)
    |=> state_q == ST_NONCRIT)
    else $error("Non-critical event did not enter non-critical");
  AST_CPU_DEGRADED: assert property ( // [R15]
    !cond_q[`COND_POST_STOP] && !crit && !noncrit && (|cpu_disabled)
    |=> state_q == ST_DEGRADED)
    else $error("Disabled processor did not enter degraded");
  AST_ID_HOLD: assert property ( // [R16]
    !(id_button && !id_prev_q) |=> $stable(id_led))
    else $error("ID LED changed without a press");

  COV_CRIT: cover property (state_q == ST_CRIT ##1 state_q == ST_NORMAL);
  COV_CLEAR: cover property (fault_led.dimm[0] ##1 !fault_led.dimm[0]);
  COV_ID: cover property (id_led ##[1:20] !id_led);
  COV_PWR_FAIL: cover property ($rose(pwr_fail_q));
  COV_BLINK: cover property (board_status_led.green ##1 !board_status_led.green);
endmodule
`default_nettype wire

// ==== panel_model.sv ====
// Front panel model: ID button, panel reset and main power
`timescale 1ns/100ps
`default_nettype none
module panel_model (
  // Clock
  input wire logic clk,
  // Panel lines
  output var logic id_button,
  output var logic fp_reset,
  output var logic main_power
);
  // Idle panel, main power present
  initial begin
    id_button = 1'b0;
    fp_reset = 1'b0;
    main_power = 1'b1;
  end
  task automatic press_id();
    @(posedge clk) id_button <= 1'b1;
    repeat (2) @(posedge clk);
    id_button <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // panel reset, main power as given
  task automatic panel_reset(input logic pwr);
    @(posedge clk) main_power <= pwr;
    fp_reset <= 1'b1;
    @(posedge clk) fp_reset <= 1'b0;
    main_power <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the indicator controller
`timescale 1ns/100ps
`default_nettype none
`include "fault_led_cfg.svh"
module tb_top import fault_led_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, slv, g;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pci_serr, proc_bus_unrec_err, ecc_present, mem_sbe, mem_dbe, sensor_event;
  logic proc_bus_error_out, nmi, smi, id_led;
  logic [5:0] dimm_uncorr;
  logic [1:0] cpu_disabled;
  logic [3:0] fan_fail;
  logic thr_crit, thr_noncrit, chassis_intrusion, cpu_install_fail;
  logic nonredundant_pwr, pwr_off_req, sys_pwr_on, main_power, fp_reset, id_button;
  logic [12:0] nv_image_in, nv_image_out;
  fault_s fault_led;
  led_s board_status_led, panel_status_led;
  int err_total = 0, compares = 0, cycles = 0, tog;
  sys_state_e cexp [4] = '{ST_CRIT, ST_NONCRIT, ST_CRIT, ST_DEGRADED};
  // Short power-fail count for simulation
  fault_led_ctrl #(.PWR_FAIL_CYCLES(8)) i_dut (.clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pci_serr, .proc_bus_unrec_err,
    .ecc_present, .mem_sbe, .mem_dbe, .sensor_event, .proc_bus_error_out, .nmi, .smi,
    .dimm_uncorr, .cpu_disabled, .fan_fail, .thr_crit, .thr_noncrit, .chassis_intrusion,
    .cpu_install_fail, .nonredundant_pwr, .pwr_off_req, .sys_pwr_on, .main_power,
    .fp_reset, .id_button, .nv_image_in, .nv_image_out, .fault_led, .board_status_led,
    .panel_status_led, .id_led);
  panel_model i_panel (.clk, .id_button, .fp_reset, .main_power);
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Settle past an edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Status state through the register
  task automatic st(input logic [4:0] s);
    repeat (3) @(posedge clk);
    apb(1'b0, `REG_STATUS, 0);
    check(rd[4:0], s);
    check(board_status_led, panel_status_led);
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      conclude();
    end
  end
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pci_serr, proc_bus_unrec_err} = '0;
    {ecc_present, mem_sbe, mem_dbe, sensor_event, dimm_uncorr, cpu_disabled} = '0;
    {fan_fail, thr_crit, thr_noncrit, chassis_intrusion, cpu_install_fail} = '0;
    {nonredundant_pwr, pwr_off_req, sys_pwr_on, nv_image_in} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `REG_CTRL, 0);
    check(rd, `CTRL_RST);
    apb(1'b0, `REG_BLINK, 0);
    check(rd, `BLINK_RST);
    apb(1'b0, 12'h020, 0);
    check(rd, 32'h0);
    check(slv, 1'b1);
    st(ST_OFF);
    // Error routing and masking
    @(posedge clk) pci_serr <= 1'b1;
    wt(1);
    check(nmi, 1'b1);
    apb(1'b1, `REG_CTRL, 32'h1E);
    wt(1);
    check(nmi, 1'b0);
    @(posedge clk) pci_serr <= 1'b0;
    proc_bus_unrec_err <= 1'b1;
    wt(1);
    check({proc_bus_error_out, nmi}, 2'b11);
    apb(1'b1, `REG_CTRL, 32'h1C);
    wt(1);
    check({proc_bus_error_out, nmi}, 2'b10);
    @(posedge clk) proc_bus_unrec_err <= 1'b0;
    ecc_present <= 1'b1;
    mem_sbe <= 1'b1;
    wt(1);
    check(smi, 1'b1);
    @(posedge clk) mem_sbe <= 1'b0;
    mem_dbe <= 1'b1;
    wt(2);
    check(smi, 1'b1);
    @(posedge clk) ecc_present <= 1'b0;
    wt(1);
    check(smi, 1'b0);
    @(posedge clk) sensor_event <= 1'b1;
    wt(1);
    check(smi, 1'b1);
    apb(1'b1, `REG_CTRL, 32'h14);
    wt(1);
    check(smi, 1'b0);
    // Memory source back, then every interrupt source masked
    @(posedge clk) ecc_present <= 1'b1;
    wt(1);
    check(smi, 1'b1);
    apb(1'b1, `REG_CTRL, 32'h10);
    wt(1);
    check({smi, nmi}, 2'b00);
    @(posedge clk) sensor_event <= 1'b0;
    mem_dbe <= 1'b0;
    ecc_present <= 1'b0;
    apb(1'b1, `REG_CTRL, `CTRL_RST);
    // Latched faults and their clearing
    @(posedge clk) dimm_uncorr <= 6'h05;
    cpu_disabled <= 2'h2;
    fan_fail <= 4'h1;
    @(posedge clk) dimm_uncorr <= 6'h00;
    cpu_disabled <= 2'h0;
    fan_fail <= 4'h0;
    wt(3);
    check(fault_led, 13'h1185);
    check(nv_image_out, 13'h1185);
    i_panel.panel_reset(1'b0);
    wt(1);
    check(fault_led, 13'h1185);
    i_panel.panel_reset(1'b1);
    wt(1);
    check(fault_led, 13'h0000);
    @(posedge clk) fan_fail <= 4'h4;
    @(posedge clk) fan_fail <= 4'h0;
    wt(2);
    check(fault_led, 13'h0400);
    apb(1'b1, `REG_CTRL, 32'h11F);
    wt(2);
    check(fault_led, 13'h0000);
    // Restore of the saved image over a reset
    @(posedge clk) nv_image_in <= 13'h0A5A;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wt(2);
    check(fault_led, 13'h0A5A);
    i_panel.press_id();
    wt(0);
    check(id_led, 1'b1);
    i_panel.press_id();
    wt(0);
    check(id_led, 1'b0);
    // Status encoding and ranking
    apb(1'b1, `REG_COND, 0);
    st(ST_NORMAL);
    check(board_status_led, 2'b10);
    apb(1'b1, `REG_BLINK, 2);
    @(posedge clk) cpu_disabled <= 2'h1;
    st(ST_DEGRADED);
    // Half period of two cycles: one phase change every second cycle
    tog = 0;
    repeat (16) begin
      g = board_status_led.green;
      wt(1);
      if (board_status_led.green !== g) tog++;
    end
    check(tog, 8);
    check(board_status_led.amber, 1'b0);
    @(posedge clk) thr_noncrit <= 1'b1;
    st(ST_NONCRIT);
    check(board_status_led.green, 1'b0);
    @(posedge clk) thr_crit <= 1'b1;
    st(ST_CRIT);
    check(board_status_led, 2'b01);
    @(posedge clk) {thr_crit, thr_noncrit, cpu_disabled} <= '0;
    chassis_intrusion <= 1'b1;
    st(ST_NONCRIT);
    @(posedge clk) chassis_intrusion <= 1'b0;
    cpu_install_fail <= 1'b1;
    st(ST_CRIT);
    @(posedge clk) cpu_install_fail <= 1'b0;
    nonredundant_pwr <= 1'b1;
    st(ST_DEGRADED);
    apb(1'b1, `REG_CTRL, 32'h0F);
    st(ST_NORMAL);
    @(posedge clk) nonredundant_pwr <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `REG_COND, 1 << i);
      st(cexp[i]);
    end
    // Power staying on after power-off
    apb(1'b1, `REG_COND, 0);
    @(posedge clk) pwr_off_req <= 1'b1;
    sys_pwr_on <= 1'b1;
    apb(1'b0, `REG_STATUS, 0);
    check(rd[9], 1'b0);
    wt(10);
    st(ST_CRIT);
    check(rd[9], 1'b1);
    @(posedge clk) sys_pwr_on <= 1'b0;
    st(ST_NORMAL);
    check(rd[9], 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
